// ---- src/tlic_pkg.sv ----
// package: constants and carrier types for the two-level interrupt controller
package tlic_pkg;

  localparam logic [20:0] high_vector_addr  = 21'h000008;
  localparam logic [20:0] low_vector_addr   = 21'h000018;
  localparam int          prio_enable_bit   = 7;
  localparam int          ctrl_high_bit     = 7;
  localparam int          ctrl_low_bit      = 6;
  localparam logic [7:0]  ctrl_reset_value  = 8'h00;
  localparam logic        prio_enable_reset = 1'b0;
  localparam logic [2:0]  edge_reset_value  = 3'h7;
  localparam int          latency_cycles    = 3;
  localparam int          num_ext           = 3;
  localparam int          num_periph        = 8;

  typedef struct packed {
    logic        take;
    logic        high;
    logic [20:0] vector;
  } tlic_entry_type;

  typedef struct packed {
    logic        high_level_global_enable;
    logic        low_level_global_enable;
  } tlic_enables_type;

endpackage : tlic_pkg

// ---- src/tlic_edge_det.sv ----
// edge/change detector that pulses event_pulse on selected edges or on any change
`timescale 1ns/1ps
`default_nettype none
module tlic_edge_det #(
  parameter int WIDTH = 3
) (
  input  wire logic             core_clk,
  input  wire logic             arst_n,
  input  wire logic [WIDTH-1:0] pin,
  input  wire logic [WIDTH-1:0] rising_sel,
  input  wire logic             any_change_mode,
  output logic      [WIDTH-1:0] event_pulse
);
  logic [WIDTH-1:0] last;
  logic             primed;

  // the first sampled value after reset is taken as the reference only
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      last   <= '0;
      primed <= 1'b0;
    end else begin
      last   <= pin;
      primed <= 1'b1;
    end
  end

  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      if (!primed)
        event_pulse[i] = 1'b0;
      else if (any_change_mode)
        event_pulse[i] = pin[i] ^ last[i];
      else if (rising_sel[i])
        event_pulse[i] = pin[i] & ~last[i];
      else
        event_pulse[i] = ~pin[i] & last[i];
    end
  end
endmodule : tlic_edge_det
`default_nettype wire

// ---- src/tlic_core.sv ----
// two-level interrupt controller: flags, gating, vector choice, entry/return
//
// How it works
// R1 - high vector is 000008h, low vector is 000018h
// R2 - high request preempts running low handler; low never preempts high
// R3 - each source has flag, enable and priority bits
// R4 - two-level priority only while priority_levels_enable is set, reset clear
// R5 - in priority mode bit 7 enables high sources, bit 6 low sources
// R6 - flag, enable and matching global enable set: vector to priority's address
// R7 - in compatibility mode priority bits are ignored
// R8 - compatibility: bit 6 gates peripherals, bit 7 gates everything
// R9 - compatibility mode always branches to 000008h
// R10 - accepting clears the global enable that admitted the request
// R11 - accept pushes return address and loads vector into program counter
// R12 - software polls flags and clears them before re-enabling
// R13 - return instruction sets the applicable global enable again
// R14 - external pin and port change latency is three to four cycles
// R15 - flags set on events regardless of any enable
// R16 - external edge select: 1 rising, 0 falling
// R17 - port change flag sets on any upper pin change, sticky
// R18 - simultaneous high and low eligible: high accepted, low stays pending
`timescale 1ns/1ps
`default_nettype none
module tlic_core
  import tlic_pkg::*;
#(
  parameter int LATENCY = latency_cycles
) (
  input  wire logic                  core_clk,
  input  wire logic                  arst_n,
  input  wire logic [num_ext-1:0]    ext_pins,
  input  wire logic [num_ext-1:0]    ext_edge_select,
  input  wire logic [num_ext-1:0]    ext_enable,
  input  wire logic [num_ext-1:0]    ext_priority,
  input  wire logic [num_ext-1:0]    ext_flag_clear,
  input  wire logic [3:0]            upper_port_pins,
  input  wire logic                  port_change_enable,
  input  wire logic                  port_change_priority,
  input  wire logic                  port_change_flag_clear,
  input  wire logic [num_periph-1:0] periph_event,
  input  wire logic [num_periph-1:0] periph_enable,
  input  wire logic [num_periph-1:0] periph_priority,
  input  wire logic [num_periph-1:0] periph_flag_clear,
  input  wire logic                  priority_levels_enable_wr,
  input  wire logic                  priority_levels_enable_in,
  input  wire logic                  ctrl_wr,
  input  wire logic [7:0]            ctrl_in,
  input  wire logic                  return_from_handler_instr,
  input  wire logic                  instr_boundary,
  input  wire logic [20:0]           pc_current,
  output logic                       priority_levels_enable,
  output logic      [7:0]            interrupt_control_reg,
  output logic      [num_ext-1:0]    ext_flag,
  output logic                       port_change_flag,
  output logic      [num_periph-1:0] peripheral_flag_reg_one,
  output logic                       stack_push,
  output logic      [20:0]           stack_push_data,
  output logic                       pc_load,
  output logic      [20:0]           pc_load_value,
  output logic                       in_high_handler,
  output logic                       in_low_handler
);
  import tlic_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // event detection
  logic [num_ext-1:0] ext_evt;
  logic [3:0]         port_evt;
  logic               high_gie;
  logic               low_gie;

  tlic_edge_det #(.WIDTH(num_ext)) u_ext (
    .core_clk        (core_clk),
    .arst_n          (arst_n),
    .pin             (ext_pins),
    .rising_sel      (ext_edge_select),
    .any_change_mode (1'b0),
    .event_pulse     (ext_evt)
  ); // [R16]

  tlic_edge_det #(.WIDTH(4)) u_port (
    .core_clk        (core_clk),
    .arst_n          (arst_n),
    .pin             (upper_port_pins),
    .rising_sel      (4'h0),
    .any_change_mode (1'b1),
    .event_pulse     (port_evt)
  ); // [R17]

  ////////////////////////////////////////////////////////////////////////////
  // sticky flags: a set in the same cycle as a clear wins
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ext_flag                <= '0;
      port_change_flag        <= 1'b0;
      peripheral_flag_reg_one <= '0;
    end else begin
      ext_flag <= (ext_flag & ~ext_flag_clear) | ext_evt; // [R15] [R3]
      port_change_flag <= (port_change_flag & ~port_change_flag_clear)
                          | (|port_evt); // [R17] [R15]
      peripheral_flag_reg_one <= (peripheral_flag_reg_one & ~periph_flag_clear)
                                 | periph_event; // [R15]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // priority mode bit
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n)
      priority_levels_enable <= prio_enable_reset; // [R4]
    else if (priority_levels_enable_wr)
      priority_levels_enable <= priority_levels_enable_in;
  end

  ////////////////////////////////////////////////////////////////////////////
  // eligibility
  logic [num_ext:0]   core_req;
  logic [num_ext:0]   core_pri;
  logic               any_high;
  logic               any_low;
  logic               comp_req;
  logic               raw_ok;
  logic [LATENCY-1:0] dly_high;
  logic [LATENCY-1:0] dly_low;
  logic               accept_high;
  logic               accept_low;
  tlic_entry_type     entry;

  assign core_req = {port_change_flag & port_change_enable,
                     ext_flag & ext_enable}; // [R3]
  assign core_pri = {port_change_priority, ext_priority};

  always_comb begin
    any_high = |(core_req & core_pri) |
               |(peripheral_flag_reg_one & periph_enable & periph_priority);
    any_low  = |(core_req & ~core_pri) |
               |(peripheral_flag_reg_one & periph_enable & ~periph_priority);
    // peripheral group enable gates only the peripheral sources
    comp_req = (|core_req) | (low_gie &
               (|(peripheral_flag_reg_one & periph_enable))); // [R8] [R7]
    if (priority_levels_enable)
      raw_ok = 1'b0;
    else
      raw_ok = high_gie & comp_req & ~in_high_handler; // [R8]
  end

  // pipeline models the synchroniser and fetch latency; with the accept
  // boundary this totals four cycles from the event to the accept, more while instr_boundary is low
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      dly_high <= '0;
      dly_low  <= '0;
    end else begin
      dly_high <= {dly_high[LATENCY-2:0],
                   priority_levels_enable ? (any_high & high_gie)
                                          : raw_ok}; // [R5] [R14]
      dly_low  <= {dly_low[LATENCY-2:0],
                   priority_levels_enable & any_low & low_gie}; // [R5] [R14]
    end
  end

  always_comb begin
    accept_high = instr_boundary & dly_high[LATENCY-1] & high_gie
                  & ~in_high_handler; // [R2] [R6]
    accept_low  = instr_boundary & dly_low[LATENCY-1] & low_gie
                  & ~accept_high & ~in_high_handler & ~in_low_handler
                  & priority_levels_enable; // [R18] [R2]
    entry.take  = accept_high | accept_low;
    entry.high  = accept_high;
    if (!priority_levels_enable)
      entry.vector = high_vector_addr; // [R9]
    else if (accept_high)
      entry.vector = high_vector_addr; // [R1]
    else
      entry.vector = low_vector_addr; // [R1]
  end

  ////////////////////////////////////////////////////////////////////////////
  // global enables: hardware clear on entry, set on return, else software
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      high_gie <= ctrl_reset_value[ctrl_high_bit];
      low_gie  <= ctrl_reset_value[ctrl_low_bit];
    end else if (entry.take) begin
      if (!priority_levels_enable || entry.high)
        high_gie <= 1'b0; // [R10]
      else
        low_gie <= 1'b0; // [R10]
    end else if (return_from_handler_instr) begin
      if (!priority_levels_enable || in_high_handler)
        high_gie <= 1'b1; // [R13]
      else
        low_gie <= 1'b1; // [R13]
    end else if (ctrl_wr) begin
      high_gie <= ctrl_in[ctrl_high_bit];
      low_gie  <= ctrl_in[ctrl_low_bit];
    end
  end

  always_comb begin
    interrupt_control_reg                = '0;
    interrupt_control_reg[ctrl_high_bit] = high_gie;
    interrupt_control_reg[ctrl_low_bit]  = low_gie;
  end

  ////////////////////////////////////////////////////////////////////////////
  // handler nesting state
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      in_high_handler <= 1'b0;
      in_low_handler  <= 1'b0;
    end else if (entry.take) begin
      if (entry.high)
        in_high_handler <= 1'b1; // [R2]
      else
        in_low_handler <= 1'b1;
    end else if (return_from_handler_instr) begin
      // the innermost handler ends first
      if (in_high_handler)
        in_high_handler <= 1'b0;
      else
        in_low_handler <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // program counter and stack
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      stack_push      <= 1'b0;
      stack_push_data <= '0;
      pc_load         <= 1'b0;
      pc_load_value   <= '0;
    end else begin
      stack_push      <= entry.take; // [R11]
      pc_load         <= entry.take; // [R11]
      if (entry.take) begin
        stack_push_data <= pc_current; // [R11]
        pc_load_value   <= entry.vector; // [R6]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_vec_compat;
    @(posedge core_clk) disable iff (!arst_n)
      (entry.take && !priority_levels_enable) |=>
        (pc_load && pc_load_value == 21'h000008);
  endproperty
  a_vec_compat: assert property (p_vec_compat) // [R9]
    else $error("compat entry not at high vector");

  property p_vec_low;
    @(posedge core_clk) disable iff (!arst_n)
      accept_low |=> (pc_load_value == 21'h000018 && !low_gie);
  endproperty
  a_vec_low: assert property (p_vec_low) // [R1] [R10]
    else $error("low entry wrong vector or enable kept");

  property p_high_clears;
    @(posedge core_clk) disable iff (!arst_n)
      accept_high |=> !high_gie && in_high_handler;
  endproperty
  a_high_clears: assert property (p_high_clears) // [R10] [R2]
    else $error("high entry did not clear enable");

  property p_no_low_in_high;
    @(posedge core_clk) disable iff (!arst_n)
      in_high_handler |-> !accept_low;
  endproperty
  a_no_low_in_high: assert property (p_no_low_in_high) // [R2]
    else $error("low request preempted high handler");

  // the losing low request must keep its enable and stay pending
  property p_high_first;
    @(posedge core_clk) disable iff (!arst_n)
      (accept_high && dly_low[LATENCY-1] && low_gie) |-> !accept_low ##1
        (low_gie && in_low_handler == $past(in_low_handler));
  endproperty
  a_high_first: assert property (p_high_first) // [R18]
    else $error("low accepted together with high");

  property p_flag_set;
    @(posedge core_clk) disable iff (!arst_n)
      periph_event[0] |=> peripheral_flag_reg_one[0];
  endproperty
  a_flag_set: assert property (p_flag_set) // [R15]
    else $error("flag not set on event");

  property p_port_change;
    @(posedge core_clk) disable iff (!arst_n)
      ($past(upper_port_pins) != upper_port_pins && $past(arst_n))
        |=> port_change_flag;
  endproperty
  a_port_change: assert property (p_port_change) // [R17]
    else $error("port change flag missed");

  property p_return_sets;
    @(posedge core_clk) disable iff (!arst_n)
      (return_from_handler_instr && !entry.take && !priority_levels_enable)
        |=> high_gie;
  endproperty
  a_return_sets: assert property (p_return_sets) // [R13]
    else $error("return did not set enable");

  property p_push_with_load;
    @(posedge core_clk) disable iff (!arst_n)
      entry.take |=> stack_push && stack_push_data == $past(pc_current);
  endproperty
  a_push_with_load: assert property (p_push_with_load) // [R11]
    else $error("no push on entry");

  c_high: cover property (@(posedge core_clk) accept_high);
  c_low: cover property (@(posedge core_clk) accept_low);
  c_nest: cover property (@(posedge core_clk)
    in_low_handler && accept_high);
  c_ret: cover property (@(posedge core_clk)
    return_from_handler_instr && in_high_handler);

endmodule : tlic_core
`default_nettype wire

// ---- sim/tlic_cpu_model.sv ----
// behavioural processor core: program counter, return stack, handler return
`timescale 1ns/1ps
`default_nettype none
module tlic_cpu_model (
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic        stack_push,
  input  wire logic [20:0] stack_push_data,
  input  wire logic        pc_load,
  input  wire logic [20:0] pc_load_value,
  output logic             instr_boundary,
  output logic      [20:0] pc_current,
  output logic             return_from_handler_instr
);
  logic [20:0] ret_stack [$];
  initial begin
    instr_boundary = 1'b1;
    return_from_handler_instr = 1'b0;
  end
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pc_current <= 21'h000100;
      ret_stack.delete();
    end else if (pc_load) begin
      if (stack_push) ret_stack.push_back(stack_push_data);
      pc_current <= pc_load_value;
    end else if (return_from_handler_instr && ret_stack.size() > 0) begin
      pc_current <= ret_stack.pop_back();
    end else if (instr_boundary) begin
      pc_current <= pc_current + 21'h000001;
    end
  end
  // a multi-cycle instruction: no accept point for n cycles
  task automatic hold_boundary(input int n);
    @(negedge core_clk) instr_boundary = 1'b0;
    repeat (n) @(negedge core_clk);
    instr_boundary = 1'b1;
  endtask : hold_boundary
  task automatic do_return();
    @(negedge core_clk) return_from_handler_instr = 1'b1;
    @(negedge core_clk) return_from_handler_instr = 1'b0;
  endtask : do_return
endmodule : tlic_cpu_model
`default_nettype wire

// ---- sim/tlic_core_tb_top.sv ----
// self-checking testbench of the interrupt controller core
`timescale 1ns/1ps
`default_nettype none
module tlic_core_tb_top;
  import tlic_pkg::*;
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_errors++; \
  $display("mismatch t=%0t got %h exp %h", $time, a, b); end end
  logic core_clk, arst_n, ple_wr, ple_in, ctrl_wr, pc_ld, st_push, ib, ret;
  logic port_en, port_pri, port_clr, ple, port_flag, in_hi, in_lo;
  logic [2:0]  ext_pins, ext_sel, ext_en, ext_pri, ext_clr, ext_flag;
  logic [3:0]  upper;
  logic [7:0]  p_ev, p_en, p_pri, p_clr, p_flag, ctrl_in, ctrl;
  logic [20:0] pc_cur, push_d, pc_val;
  int          n_errors, tests_run;
  tlic_core dut (.core_clk(core_clk), .arst_n(arst_n), .ext_pins(ext_pins),
    .ext_edge_select(ext_sel), .ext_enable(ext_en), .ext_priority(ext_pri),
    .ext_flag_clear(ext_clr), .upper_port_pins(upper),
    .port_change_enable(port_en), .port_change_priority(port_pri),
    .port_change_flag_clear(port_clr), .periph_event(p_ev),
    .periph_enable(p_en), .periph_priority(p_pri),
    .periph_flag_clear(p_clr), .priority_levels_enable_wr(ple_wr),
    .priority_levels_enable_in(ple_in), .ctrl_wr(ctrl_wr),
    .ctrl_in(ctrl_in), .return_from_handler_instr(ret),
    .instr_boundary(ib), .pc_current(pc_cur),
    .priority_levels_enable(ple), .interrupt_control_reg(ctrl),
    .ext_flag(ext_flag), .port_change_flag(port_flag),
    .peripheral_flag_reg_one(p_flag), .stack_push(st_push),
    .stack_push_data(push_d), .pc_load(pc_ld), .pc_load_value(pc_val),
    .in_high_handler(in_hi), .in_low_handler(in_lo));
  tlic_cpu_model cpu (.core_clk(core_clk), .arst_n(arst_n),
    .stack_push(st_push), .stack_push_data(push_d), .pc_load(pc_ld),
    .pc_load_value(pc_val), .instr_boundary(ib), .pc_current(pc_cur),
    .return_from_handler_instr(ret));
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report
  task automatic wr_ctrl(input logic [7:0] v);
    @(negedge core_clk) begin ctrl_wr = 1'b1; ctrl_in = v; end
    @(negedge core_clk) ctrl_wr = 1'b0;
  endtask : wr_ctrl
  // clear pulses are one cycle wide
  task automatic clr(input logic [2:0] e, input logic [7:0] p);
    @(negedge core_clk) begin ext_clr = e; p_clr = p; port_clr = 1'b1; end
    @(negedge core_clk) begin ext_clr = '0; p_clr = '0; port_clr = 1'b0; end
  endtask : clr
  task automatic wait_entry(input logic [20:0] v, input logic hi);
    int k;
    logic [20:0] prev;
    prev = pc_cur;
    // prev holds the core's address during the accepting cycle
    for (k = 0; k < 14 && pc_ld !== 1'b1; k++) begin
      prev = pc_cur;
      @(negedge core_clk);
    end
    `CHK(pc_ld, 1'b1)
    `CHK(st_push, 1'b1)
    `CHK(pc_val, v)
    `CHK(in_hi, hi)
    `CHK(push_d, prev)
  endtask : wait_entry
  task automatic no_entry(input int n);
    logic seen;
    seen = 1'b0;
    repeat (n) @(negedge core_clk) seen |= (pc_ld === 1'b1);
    `CHK(seen, 1'b0)
  endtask : no_entry
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #20000;
    n_errors++;
    final_report();
  end
  initial begin
    arst_n = 1'b0; ple_wr = 1'b0; ple_in = 1'b0; ctrl_wr = 1'b0;
    ctrl_in = '0; ext_pins = 3'h2; ext_sel = 3'h1; ext_en = '0;
    ext_pri = '0; ext_clr = '0; upper = '0; port_en = 1'b0;
    port_pri = 1'b0; port_clr = 1'b0; p_ev = '0; p_en = '0; p_pri = '0;
    p_clr = '0; n_errors = 0; tests_run = 0;
    repeat (5) @(negedge core_clk);
    arst_n = 1'b1;
    repeat (2) @(negedge core_clk);
    `CHK(ple, 1'b0)
    `CHK(ctrl, 8'h00)
    // rising on 0 (select 1), falling on 1, rising on 2 with select 0
    ext_pins = 3'h5;
    repeat (3) @(negedge core_clk);
    `CHK(ext_flag, 3'h3)
    upper[2] = 1'b1;
    repeat (4) @(negedge core_clk);
    `CHK(port_flag, 1'b1)
    `CHK(pc_ld, 1'b0)
    clr(3'h7, 8'h00);
    `CHK({port_flag, ext_flag}, 4'h0)
    // compatibility: bit 6 gates peripherals, priority bit ignored
    p_en = 8'h01;
    wr_ctrl(8'h80);
    @(negedge core_clk) p_ev = 8'h01;
    @(negedge core_clk) p_ev = 8'h00;
    `CHK(p_flag, 8'h01)
    no_entry(8);
    fork cpu.hold_boundary(6); join_none
    wr_ctrl(8'hc0);
    no_entry(4);
    wait_entry(high_vector_addr, 1'b1);
    @(negedge core_clk);
    `CHK(ctrl, 8'h40)
    clr(3'h0, 8'h01);
    cpu.do_return();
    @(negedge core_clk);
    `CHK(ctrl, 8'hc0)
    // two levels: low entry, then high preempts
    @(negedge core_clk) begin ple_wr = 1'b1; ple_in = 1'b1; end
    @(negedge core_clk) ple_wr = 1'b0;
    `CHK(ple, 1'b1)
    ext_en = 3'h3; ext_pri = 3'h3;
    @(negedge core_clk) p_ev = 8'h01;
    @(negedge core_clk) p_ev = 8'h00;
    wait_entry(low_vector_addr, 1'b0);
    @(negedge core_clk);
    `CHK({ctrl, in_lo}, 9'h101)
    @(negedge core_clk) ext_pins = 3'h4;
    @(negedge core_clk) ext_pins = 3'h5;
    wait_entry(high_vector_addr, 1'b1);
    @(negedge core_clk);
    `CHK(ctrl, 8'h00)
    clr(3'h7, 8'h01);
    cpu.do_return();
    @(negedge core_clk);
    `CHK({ctrl, in_hi, in_lo}, 10'h201)
    cpu.do_return();
    @(negedge core_clk);
    `CHK({ctrl, in_lo}, 9'h180)
    // same-cycle high and low: high first, low waits
    p_en = 8'h02;
    ext_pins = 3'h4;
    // rising edge on pin 0 (high) meets peripheral event 1 (low)
    @(negedge core_clk) begin p_ev = 8'h02; ext_pins = 3'h5; end
    @(negedge core_clk) p_ev = 8'h00;
    wait_entry(high_vector_addr, 1'b1);
    no_entry(8);
    `CHK(p_flag, 8'h02)
    clr(3'h7, 8'h00);
    cpu.do_return();
    wait_entry(low_vector_addr, 1'b0);
    final_report();
  end
`undef CHK
endmodule : tlic_core_tb_top
`default_nettype wire
